// ==== core/esa_pkg.sv ====
// Package: offsets, field layouts and types of the enable-pin supply block
package esa_pkg;

   // Register offsets on the control serial port register space
   localparam logic [7:0] ESA_OFF_REG_KEEP = 8'h41;
   localparam logic [7:0] ESA_OFF_RES_KEEP = 8'h42;
   localparam logic [7:0] ESA_OFF_SLEEP_OFF = 8'h44;
   localparam logic [7:0] ESA_OFF_EN1_REG = 8'h45;
   localparam logic [7:0] ESA_OFF_EN1_CONV = 8'h46;
   localparam logic [7:0] ESA_OFF_EN2_REG = 8'h47;
   localparam logic [7:0] ESA_OFF_EN2_CONV = 8'h48;
   localparam logic [7:0] ESA_OFF_EN3_REG = 8'h49;

   // Reset values
   localparam logic [7:0] ESA_RST_VAL = 8'h00;

   // Converter field positions in assignment, keep and sleep-off registers
   localparam int ESA_BIT_IO = 0;
   localparam int ESA_BIT_CORE1 = 1;
   localparam int ESA_BIT_CORE2 = 2;
   localparam int ESA_BIT_THIRD = 3;
   localparam int ESA_BIT_SPARE = 4;
   localparam int ESA_NUM_REG = 8;
   localparam int ESA_NUM_CONV = 4;

   // Write masks: second converter register has read-only top bits
   localparam logic [7:0] ESA_MASK_ALL = 8'hFF;
   localparam logic [7:0] ESA_MASK_EN2_CONV = 8'h1F;
   localparam logic [7:0] ESA_MASK_SLEEP_OFF = 8'h1F;

   // Supply states driven to the power stages
   typedef enum logic [1:0]
   {
      ESA_ST_OFF = 2'h0,
      ESA_ST_LOW = 2'h1,
      ESA_ST_ON = 2'h3,
      ESA_ST_FREE = 2'h2
   } esa_state_t;

   // Voltage source for a core converter
   typedef enum logic [1:0]
   {
      ESA_VSEL_REG = 2'h0,
      ESA_VSEL_OP = 2'h1,
      ESA_VSEL_SLP = 2'h3
   } esa_vsel_t;

   // Register write request
   typedef struct packed
   {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } esa_wr_t;

   // Three synchronised enable inputs
   typedef struct packed
   {
      logic en3;
      logic en2;
      logic en1;
   } esa_en_t;

endpackage : esa_pkg

// ==== core/esa_sync.sv ====
// Two-flop synchroniser for the enable input pins
`timescale 1ns/1ns
module esa_sync
   import esa_pkg::*;
#(
   parameter int WIDTH = 3
)
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Raw and synchronised levels
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   // State: first and second stage
   typedef struct packed
   {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } esa_sync_st_t;

   esa_sync_st_t st_q; // Registered state
   esa_sync_st_t st_d; // Next state

   // Next state; first stage feeds only the second
   always_comb
   begin
      st_d = st_q;
      st_d.meta = i_async;
      st_d.sync = st_q.meta;
   end

   // State register, synchronous reset
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign o_sync = st_q.sync;

endmodule : esa_sync

// ==== core/esa_decide.sv ====
// Per-supply state decision for one supply under one enable input
`timescale 1ns/1ns
module esa_decide
   import esa_pkg::*;
(
   // Assignment, enable level, keep-on bit and fallback state
   input wire logic i_assigned,
   input wire logic i_enable,
   input wire logic i_keep,
   input wire esa_state_t i_fallback,
   // Resulting state
   output esa_state_t o_state
);

   // Assigned: high is on, low is off or low power by keep bit
   always_comb
   begin
      if (!i_assigned)
      begin
         o_state = i_fallback;
      end
      else if (i_enable)
      begin
         o_state = ESA_ST_ON;
      end
      else if (i_keep)
      begin
         o_state = ESA_ST_LOW;
      end
      else
      begin
         o_state = ESA_ST_OFF;
      end
   end

endmodule : esa_decide

// ==== core/esa_enable_assign.sv ====
// Enable-pin supply assignment: registers and supply state decisions
//
// Summary of operation
// - Sleep-off bit turns an unassigned converter off in sleep unless kept on
// - First regulator assignment: on while first enable high
// - Low enable: keep bit picks low power, else off
// - Unassigned supply follows registers and device state
// - Any first or second enable assignment bit disables voltage-scaling serial port
// - Regulator bits: dac, pll, aux, digital, card
// - First converter assignment: reserved, spare, four converters
// - Third converter on high, low sets off/low power
// - Core voltage: operating when high, sleep when low
// - Core low enable keep: low power unless sleep off
// - I/O converter on high, low off or low power
// - Second regulator assignment uses second enable input
// - Second converter assignment; top bits read zero
// - Third converter on second enable, same low behaviour
// - Third regulator assignment uses third enable input
// - Regulator keep-on register, one bit per regulator
// - Resource keep bits for core two, one, I/O
`timescale 1ns/1ns
module esa_enable_assign
   import esa_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Register write port from the control serial port
   input wire esa_wr_t i_wr,
   // Register read port
   input wire logic [7:0] i_rd_addr,
   output logic [7:0] o_rd_data,
   // Enable input pins driven by the host
   input wire logic i_first_enable_input,
   input wire logic i_second_enable_input,
   input wire logic i_third_enable_input,
   // Device state and register-programmed fallback states
   input wire logic i_dev_sleep,
   input wire esa_state_t [ESA_NUM_REG-1:0] i_reg_prog_state,
   input wire esa_state_t [ESA_NUM_CONV-1:0] i_conv_prog_state,
   // Core converter sleep voltage programmed off (bit0 core one)
   input wire logic [1:0] i_core_sleep_volt_off,
   // Supply states and core voltage selection, all combinational
   // from the registers, the synchronised pins and the inputs
   output esa_state_t [ESA_NUM_REG-1:0] o_reg_state,
   output esa_state_t [ESA_NUM_CONV-1:0] o_conv_state,
   output esa_vsel_t [1:0] o_core_vsel,
   // Voltage-scaling serial port enable
   output logic o_vs_port_enable
);

   // All register state of the block except the pin synchroniser
   // Read data kept here too: one register stage for both paths,
   // so o_rd_data lags the read address by one edge
   // Keep-on and switch-off copies feed the decisions every cycle
   // Eight-bit fields, so offsets map one to one
   typedef struct packed
   {
      logic [7:0] reg_keep;    // Regulator keep-on bits
      logic [7:0] res_keep;    // Resource keep-on bits
      logic [7:0] sleep_off;   // Converter sleep switch-off
      logic [7:0] en1_reg;     // First regulator assignment
      logic [7:0] en1_conv;    // First converter assignment
      logic [7:0] en2_reg;     // Second regulator assignment
      logic [7:0] en2_conv;    // Second converter assignment
      logic [7:0] en3_reg;     // Third regulator assignment
      logic [7:0] rd_data;     // Registered read data
      logic vs_en;             // Serial port enable
   } esa_st_t;

   esa_st_t st_q; // Registered state
   esa_st_t st_d; // Next state
   esa_en_t en_s; // Synchronised enables
   // Raw pins never read past the synchroniser: a pin edge near
   // the clock could give two supplies on one enable different
   // states for a cycle

   // Masked write of one register
   // Read-only fields keep their reset zero and read back as zero
   function automatic logic [7:0] wmask(input logic [7:0] old,
                                        input logic [7:0] val,
                                        input logic [7:0] msk);
      // Old bits where the mask is clear, new ones where it is set
      wmask = (old & ~msk) | (val & msk);
   endfunction : wmask

   // Pin synchroniser; bit 0 carries the first enable
   // A pin change reaches the supply outputs two edges later
   esa_sync #(.WIDTH(3)) u_sync
   (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_async({i_third_enable_input, i_second_enable_input,
                i_first_enable_input}),
      .o_sync(en_s)
   );

   // Next state: register writes and read mux
   // Read mux looks at st_q: a read of the register being written
   // returns the old value
   always_comb
   begin
      // Hold everything unless written
      st_d = st_q;
      if (i_wr.wr)
      begin
         // Unmapped offsets fall to the default and change nothing
         case (i_wr.addr)
            ESA_OFF_REG_KEEP: st_d.reg_keep = i_wr.data;
            ESA_OFF_RES_KEEP: st_d.res_keep = i_wr.data;
            ESA_OFF_SLEEP_OFF:
            begin
               // Top bits belong to other functions, not held here
               st_d.sleep_off = wmask(st_q.sleep_off, i_wr.data,
                                      ESA_MASK_SLEEP_OFF);
            end
            ESA_OFF_EN1_REG: st_d.en1_reg = i_wr.data;
            // First converter register: reserved and spare writable
            ESA_OFF_EN1_CONV: st_d.en1_conv = i_wr.data;
            ESA_OFF_EN2_REG: st_d.en2_reg = i_wr.data;
            ESA_OFF_EN2_CONV:
            begin
               // Top three bits are read-only and stay zero
               st_d.en2_conv = wmask(st_q.en2_conv, i_wr.data,
                                     ESA_MASK_EN2_CONV);
            end
            ESA_OFF_EN3_REG: st_d.en3_reg = i_wr.data;
            default:
            begin
               // Not ours: every register stays as it is
               st_d.reg_keep = st_q.reg_keep;
            end
         endcase
      end
      // Read data registered; unmapped reads give zero
      // Masked registers hold zeros in their read-only bits, so no
      // masking is needed on the way out
      case (i_rd_addr)
         ESA_OFF_REG_KEEP: st_d.rd_data = st_q.reg_keep;
         ESA_OFF_RES_KEEP: st_d.rd_data = st_q.res_keep;
         ESA_OFF_SLEEP_OFF: st_d.rd_data = st_q.sleep_off;
         ESA_OFF_EN1_REG: st_d.rd_data = st_q.en1_reg;
         ESA_OFF_EN1_CONV: st_d.rd_data = st_q.en1_conv;
         ESA_OFF_EN2_REG: st_d.rd_data = st_q.en2_reg;
         ESA_OFF_EN2_CONV: st_d.rd_data = st_q.en2_conv;
         ESA_OFF_EN3_REG: st_d.rd_data = st_q.en3_reg;
         default: st_d.rd_data = 8'h00;
      endcase
      // Shared pins: any assignment bit takes them from the port
      // Next values used, so the port drops at the very edge of the
      // write that claims the pins, not one edge later
      // Third enable has a pin of its own and is left out
      // A later write of zeros gives the pins back to the port
      st_d.vs_en = ~(|st_d.en1_reg | |st_d.en1_conv |
                     |st_d.en2_reg | |st_d.en2_conv);
   end

   // State register, synchronous reset
   // Everything, read data included, clears to zero; only the
   // port enable sets, as no supply is tied to a pin out of reset
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         // Nothing assigned after reset, so the serial port is free
         st_q <= '{default: '0, vs_en: 1'b1};
      end
      else
      begin
         // Next state taken on every edge
         st_q <= st_d;
      end
   end

   // Regulators: the lowest-numbered enable claiming a bit wins
   // Several claims on one regulator are a programming slip; a
   // fixed priority keeps the outcome predictable instead of
   // letting the last write decide
   // One loop variable serves both supply loops
   genvar g;
   generate
      for (g = 0; g < ESA_NUM_REG; g++)
      begin : g_reg
         logic asg; // Assigned to any enable
         logic lvl; // Level of the claiming enable
         // Claim and level of the winning enable
         always_comb
         begin
            // Claimed by any of the three enables
            asg = st_q.en1_reg[g] | st_q.en2_reg[g] | st_q.en3_reg[g];
            // Priority: first, then second, then third enable
            if (st_q.en1_reg[g])
            begin
               lvl = en_s.en1;
            end
            else if (st_q.en2_reg[g])
            begin
               lvl = en_s.en2;
            end
            else
            begin
               // Third enable, unused when nothing claims
               lvl = en_s.en3;
            end
         end
         // On, low power, off or register state
         esa_decide u_dec
         (
            .i_assigned(asg),
            .i_enable(lvl),
            .i_keep(st_q.reg_keep[g]),
            .i_fallback(i_reg_prog_state[g]),
            .o_state(o_reg_state[g])
         );
      end
   endgenerate

   // Converters: first enable wins over second when both claim
   // No third-enable converter register, so two claims only
   // Index 0 I/O converter, 1 and 2 cores, 3 third converter
   // Keep bits from the resource keep-on register
   generate
      for (g = 0; g < ESA_NUM_CONV; g++)
      begin : g_conv
         logic asg;       // Assigned to an enable
         logic lvl;       // Claiming enable level
         logic keep;      // Effective keep bit
         esa_state_t fb;  // Fallback state
         esa_state_t dec; // Decided state
         // Core override applies after the shared decision
         // Claim, level and keep bit for this converter
         always_comb
         begin
            asg = st_q.en1_conv[g] | st_q.en2_conv[g];
            // Second enable only when the first leaves it alone
            lvl = st_q.en1_conv[g] ? en_s.en1 : en_s.en2;
            keep = st_q.res_keep[g];
            // Sleep switch-off only when not kept on; it shapes the
            // fallback only, so an assigned converter ignores it
            if (i_dev_sleep && st_q.sleep_off[g] && !keep)
            begin
               fb = ESA_ST_OFF;
            end
            else
            begin
               // Otherwise what the register programming asks
               fb = i_conv_prog_state[g];
            end
         end
         // Same decision as the regulators, resource keep bit
         esa_decide u_dec
         (
            .i_assigned(asg),
            .i_enable(lvl),
            .i_keep(keep),
            .i_fallback(fb),
            .o_state(dec)
         );
         // Core converters: sleep voltage programmed off wins
         // Voltage select names the register the stage uses;
         // unassigned cores stay on register programming
         if (g == ESA_BIT_CORE1 || g == ESA_BIT_CORE2)
         begin : g_core
            always_comb
            begin
               // Low enable with sleep voltage off gives off
               if (asg && !lvl && i_core_sleep_volt_off[g-1])
               begin
                  o_conv_state[g] = ESA_ST_OFF;
               end
               else
               begin
                  o_conv_state[g] = dec;
               end
               // Voltage source follows the claiming enable
               if (!asg)
               begin
                  o_core_vsel[g-1] = ESA_VSEL_REG;
               end
               else if (lvl)
               begin
                  o_core_vsel[g-1] = ESA_VSEL_OP;
               end
               else
               begin
                  o_core_vsel[g-1] = ESA_VSEL_SLP;
               end
            end
         end
         else
         begin : g_plain
            // I/O and third converter take the decision as is
            assign o_conv_state[g] = dec;
         end
      end
   endgenerate

   // Outputs straight from flip-flops
   assign o_rd_data = st_q.rd_data;
   assign o_vs_port_enable = st_q.vs_en;

endmodule : esa_enable_assign

// ==== tb/esa_host_pins.sv ====
// Host model that drives the three enable pins of the block
`timescale 1ns/1ns
module esa_host_pins
(
   // Clock
   input wire logic i_sys_clk,
   // Levels the host wants, bit 0 first input
   input wire logic [2:0] i_want,
   // Enable pins
   output logic [2:0] o_en = 3'h0
);
   // Pins move away from the sampling edge, as a real host would
   always @(negedge i_sys_clk)
   begin
      o_en <= i_want;
   end
endmodule : esa_host_pins

// ==== tb/esa_enable_assign_chk.sv ====
// Concurrent checks on the enable-pin supply assignment ports
`timescale 1ns/1ns
module esa_enable_assign_chk
   import esa_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Register port
   input wire esa_wr_t i_wr,
   input wire logic [7:0] i_rd_addr,
   input wire logic [7:0] o_rd_data,
   // First enable pin and fallback
   input wire logic i_first_enable_input,
   input wire esa_state_t [ESA_NUM_REG-1:0] i_reg_prog_state,
   // Results
   input wire esa_state_t [ESA_NUM_REG-1:0] o_reg_state,
   input wire esa_state_t [ESA_NUM_CONV-1:0] o_conv_state,
   input wire esa_vsel_t [1:0] o_core_vsel,
   input wire logic o_vs_port_enable
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_reset);
   logic [7:0] s [8'h41:8'h49]; // Shadow of written registers
   logic e1; // Short name for the first pin
   assign e1 = i_first_enable_input;
   // Shadow copy; only low bits are used, so masks do not matter
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
         s <= '{default: 8'h00};
      else if (i_wr.wr && (i_wr.addr inside {[8'h41:8'h49]}))
         s[i_wr.addr] <= i_wr.data;
   end
   a_top_bits_zero: assert property (i_rd_addr == 8'h48
      |=> o_rd_data[7:5] == 3'h0) else $error("top bits read nonzero");
   a_vs_port_off: assert property (i_wr.wr && (i_wr.addr inside
      {[8'h45:8'h48]}) && (i_wr.data & 8'h1F) != 8'h00
      |=> !o_vs_port_enable) else $error("serial port left enabled");
   a_reg_on_high: assert property (e1[*3] ##0 s[8'h45][0]
      |-> o_reg_state[0] == ESA_ST_ON) else $error("regulator not on");
   a_reg_low_keep: assert property ((!e1)[*3] ##0 s[8'h45][0]
      |-> o_reg_state[0] == (s[8'h41][0] ? ESA_ST_LOW : ESA_ST_OFF))
      else $error("regulator low state wrong");
   a_reg_fallback: assert property (!s[8'h45][0] && !s[8'h47][0]
      && !s[8'h49][0] |-> o_reg_state[0] == i_reg_prog_state[0])
      else $error("unassigned regulator wrong");
   a_sync_two_edges: assert property (s[8'h45][0] && !s[8'h41][0]
      && $rose(e1) && !$past(e1, 2) |-> o_reg_state[0] == ESA_ST_OFF
      ##1 o_reg_state[0] == ESA_ST_OFF) else $error("pin used unsynced");
   a_third_on: assert property (e1[*3] ##0 s[8'h46][3]
      |-> o_conv_state[3] == ESA_ST_ON) else $error("third not on");
   a_core_vsel_op: assert property (e1[*3] ##0 s[8'h46][1]
      |-> o_core_vsel[0] == ESA_VSEL_OP) else $error("core vsel wrong");
   a_io_low_keep: assert property ((!e1)[*3] ##0 s[8'h46][0]
      |-> o_conv_state[0] == (s[8'h42][0] ? ESA_ST_LOW : ESA_ST_OFF))
      else $error("io converter low state wrong");
   c_write: cover property (i_wr.wr);
   c_third_low: cover property (o_conv_state[3] == ESA_ST_LOW);
   c_vs_back: cover property (!o_vs_port_enable ##1 o_vs_port_enable);
endmodule : esa_enable_assign_chk

bind esa_enable_assign esa_enable_assign_chk u_chk
(
   .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_wr(i_wr),
   .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
   .i_first_enable_input(i_first_enable_input),
   .i_reg_prog_state(i_reg_prog_state), .o_reg_state(o_reg_state),
   .o_conv_state(o_conv_state), .o_core_vsel(o_core_vsel),
   .o_vs_port_enable(o_vs_port_enable)
);

// ==== tb/esa_enable_assign_tb.sv ====
// Self-checking bench for the enable-pin supply assignment block
`timescale 1ns/1ns
module esa_enable_assign_tb import esa_pkg::*;;
   logic i_sys_clk = 1'b0; // Clock
   logic i_reset = 1'b1; // Reset, held at start
   esa_wr_t i_wr = '0; // Write request
   logic [7:0] i_rd_addr = 8'h00;
   logic [2:0] want = 3'h0; // Wanted pin levels
   logic [2:0] pin; // Pins from host model
   logic i_dev_sleep = 1'b0;
   esa_state_t [7:0] prog = '{default: ESA_ST_OFF};
   esa_state_t [3:0] cprog = '{default: ESA_ST_OFF};
   logic [1:0] svo = 2'h0; // Core sleep voltage off
   logic [7:0] o_rd_data;
   esa_state_t [7:0] o_reg_state;
   esa_state_t [3:0] o_conv_state;
   esa_vsel_t [1:0] o_core_vsel;
   logic o_vs_port_enable;
   logic [7:0] m [8'h41:8'h49]; // Register model
   int n_fail = 0;
   int compares = 0;
   integer seed = 32'hb75e4397;
   always #4 i_sys_clk = ~i_sys_clk;
   esa_host_pins u_host (.i_sys_clk(i_sys_clk), .i_want(want), .o_en(pin));
   esa_enable_assign u_dut
   (
      .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_wr(i_wr),
      .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
      .i_first_enable_input(pin[0]), .i_second_enable_input(pin[1]),
      .i_third_enable_input(pin[2]), .i_dev_sleep(i_dev_sleep),
      .i_reg_prog_state(prog), .i_conv_prog_state(cprog),
      .i_core_sleep_volt_off(svo), .o_reg_state(o_reg_state),
      .o_conv_state(o_conv_state), .o_core_vsel(o_core_vsel),
      .o_vs_port_enable(o_vs_port_enable)
   );
   task automatic summarize();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize
   // One comparison, reported at once
   task automatic chk(input logic [28:0] g, input logic [28:0] e);
      compares++;
      if (g !== e)
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      if (g !== e)
         n_fail++;
   endtask : chk
   // Writable bits of each place; unmapped keeps nothing
   function automatic logic [7:0] msk(input logic [7:0] a);
      case (a) inside
         8'h44, 8'h48: return 8'h1F;
         8'h41, 8'h42, [8'h45:8'h47], 8'h49: return 8'hFF;
         default: return 8'h00;
      endcase
   endfunction : msk
   // Write held over one rising edge, then dropped
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_sys_clk);
      i_wr = '{1'b1, a, d};
      if (a inside {[8'h41:8'h49]})
         m[a] = d & msk(a);
      @(negedge i_sys_clk);
      i_wr.wr = 1'b0;
   endtask : wr
   // Read answer lands one edge after the address
   task automatic rd(input logic [7:0] a);
      logic [7:0] e;
      e = (a inside {[8'h41:8'h49]}) ? m[a] : 8'h00;
      @(negedge i_sys_clk);
      i_rd_addr = a;
      @(negedge i_sys_clk);
      chk({21'h0, o_rd_data}, {21'h0, e});
   endtask : rd
   // Supply states worked out from the model registers and pins
   task automatic cmp();
      esa_state_t [7:0] er;
      esa_state_t [3:0] ec;
      esa_vsel_t [1:0] ev;
      logic e, a1, a2;
      for (int i = 0; i < 8; i++)
      begin
         e = m[8'h45][i] ? want[0] : m[8'h47][i] ? want[1] : want[2];
         a1 = m[8'h45][i] | m[8'h47][i] | m[8'h49][i];
         er[i] = !a1 ? prog[i] : e ? ESA_ST_ON
            : m[8'h41][i] ? ESA_ST_LOW : ESA_ST_OFF;
      end
      for (int j = 0; j < 4; j++)
      begin
         e = m[8'h46][j] ? want[0] : want[1];
         a1 = m[8'h46][j] | m[8'h48][j];
         a2 = (j == 1 && svo[0]) || (j == 2 && svo[1]);
         if (a1)
            ec[j] = e ? ESA_ST_ON : (a2 || !m[8'h42][j]) ? ESA_ST_OFF
               : ESA_ST_LOW;
         else
            ec[j] = (i_dev_sleep && m[8'h44][j] && !m[8'h42][j])
               ? ESA_ST_OFF : cprog[j];
         if (j == 1 || j == 2)
            ev[j-1] = !a1 ? ESA_VSEL_REG : e ? ESA_VSEL_OP : ESA_VSEL_SLP;
      end
      a1 = (m[8'h45] | m[8'h46] | m[8'h47] | m[8'h48]) == 8'h00;
      chk({o_reg_state, o_conv_state, o_core_vsel, o_vs_port_enable},
         {er, ec, ev, a1});
   endtask : cmp
   // Main sequence: reset values, masking, then random traffic
   initial
   begin
      m = '{default: 8'h00};
      repeat (3) @(negedge i_sys_clk);
      i_reset = 1'b0;
      for (int a = 8'h40; a <= 8'h4A; a++)
         rd(8'(a));
      cmp();
      for (int a = 8'h40; a <= 8'h4A; a++)
         wr(8'(a), 8'($random(seed)));
      for (int a = 8'h40; a <= 8'h4A; a++)
         rd(8'(a));
      for (int n = 0; n < 60; n++)
      begin
         // Full-width data, so the upper regulators get claimed too
         for (int a = 8'h41; a <= 8'h49; a++)
            wr(8'(a), ($random(seed) & 1) ? 8'($random(seed)) : 8'h00);
         @(negedge i_sys_clk);
         // Non-blocking: the host model takes it at the next fall
         want <= 3'($random(seed));
         i_dev_sleep = 1'($random(seed));
         svo = 2'($random(seed));
         for (int i = 0; i < 8; i++)
            prog[i] = esa_state_t'(2'($random(seed)));
         for (int j = 0; j < 4; j++)
            cprog[j] = esa_state_t'(2'($random(seed)));
         repeat (4) @(negedge i_sys_clk);
         cmp();
      end
      summarize();
   end
   // Watchdog well beyond the expected run length
   initial
   begin
      #200000;
      n_fail++;
      summarize();
   end
endmodule : esa_enable_assign_tb
